// *** design/vgdp_datapath.sv ***
// Vector general data processing datapath, one result per cycle
module vgdp_datapath import vgdp_pkg::*; #(
  parameter bit HALF_EN = 1'b1  // Half-precision option present
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire vgdp_req_type req_i,
  input wire logic [VEC_W-1:0] opa_i,
  input wire logic [VEC_W-1:0] opb_i,
  input wire logic [31:0] gpr_i,
  input wire logic sat_clr_i,
  output logic res_valid_o,
  output logic res_wr_o,
  output logic [VEC_W-1:0] res_o,
  output logic [31:0] status_o
);

  // Float to integer or fixed, truncating, saturating to the target range
  function automatic logic [31:0] f2fix(input logic [31:0] f, input logic [5:0] fb,
                                        input logic uns);
    logic signed [9:0] e;
    logic [63:0] t;
    e = $signed({2'b0, f[30:23]}) - $signed(F32_BIAS) + $signed({4'b0, fb});
    t = ({40'h0, 1'b1, f[22:0]} << e[5:0]) >> 23;
    if (f[30:23] == 8'hff && |f[22:0]) return 32'h0;  // NaN gives zero
    if (f[30:23] == 8'hff || e > $signed(F2I_MAX_EXP)) t = '1;
    else if (f[30:23] == 8'h0 || e < 0) t = 64'h0;  // Below one unit
    if (uns) return f[31] ? 32'h0 : (|t[63:32] ? 32'hffffffff : t[31:0]);
    if (f[31]) return (t > 64'h80000000) ? 32'h80000000 : 32'(-t);
    return (t > 64'h7fffffff) ? 32'h7fffffff : t[31:0];
  endfunction : f2fix

  // Integer or fixed to float, round to nearest even
  function automatic logic [31:0] fix2f(input logic [31:0] x, input logic [5:0] fb,
                                        input logic uns);
    logic neg;
    logic [31:0] m;
    logic [31:0] n;
    logic [5:0] lz;
    logic [30:0] body;
    neg = !uns && x[31];
    m = neg ? -x : x;
    lz = 6'h0;
    for (int k = 0; k < 32; k++) begin
      if (m[k]) lz = 6'(31 - k);
    end
    n = m << lz;
    body = {8'(F32_EXP_TOP - {2'b0, lz} - {2'b0, fb}), n[30:8]};
    body = body + 31'(n[7] & (|n[6:0] | n[8]));
    return (m == 32'h0) ? 32'h0 : {neg, body};
  endfunction : fix2f

  // Half to single; subnormal halves flush to signed zero
  function automatic logic [31:0] h2s(input logic [15:0] h);
    if (h[14:10] == 5'h0) return {h[15], 31'h0};
    if (h[14:10] == 5'h1f) return {h[15], 8'hff, h[9:0], 13'h0};
    return {h[15], 8'({3'b0, h[14:10]}) + F16_REBIAS, h[9:0], 13'h0};
  endfunction : h2s

  // Single to half, round to nearest even; tiny results flush to zero
  function automatic logic [15:0] s2h(input logic [31:0] f);
    logic signed [9:0] eu;
    logic [14:0] body;
    eu = $signed({2'b0, f[30:23]}) - $signed({2'b0, F16_REBIAS});
    if (f[30:23] == 8'hff) return {f[31], 5'h1f, |f[22:0], 9'h0};
    if (eu >= 10'sd31) return {f[31], 5'h1f, 10'h0};
    if (eu <= 10'sd0) return {f[31], 15'h0};
    body = {eu[4:0], f[22:13]};
    body = body + 15'(f[12] & (|f[11:0] | f[13]));  // Carry may reach infinity
    return {f[31], body};
  endfunction : s2h

  // Clamp to the half-width range; top bit flags saturation
  function automatic logic [32:0] sat_nar(input logic [63:0] v, input logic [1:0] es,
                                          input logic sin, input logic sout);
    logic signed [64:0] vx;
    logic signed [64:0] hi;
    logic signed [64:0] lo;
    int hw;
    hw = 8 << es;
    vx = {sin & v[63], v};
    hi = sout ? (65'sd1 <<< hw) - 65'sd1 : (65'sd1 <<< (hw - 1)) - 65'sd1;
    lo = sout ? 65'sd0 : -(65'sd1 <<< (hw - 1));
    if (vx > hi) return {1'b1, hi[31:0]};
    if (vx < lo) return {1'b1, lo[31:0]};
    return {1'b0, v[31:0]};
  endfunction : sat_nar

  logic [VEC_W-1:0] res_reg;   // Result data
  logic valid_reg;             // Operation finished
  logic wr_reg;                // Destination to be written
  logic sat_reg;               // Sticky saturation flag
  logic [VEC_W-1:0] res_next;  // Computed result
  logic sat_any;               // Some element clamped
  logic ill;                   // Encoding has no meaning here

  wire logic [5:0] fb = (req_i.fbits > FBITS_MAX) ? FBITS_MAX : req_i.fbits;
  wire logic [VEC_W-1:0] cvt_f2i;  // Per-lane float to integer
  wire logic [VEC_W-1:0] cvt_i2f;  // Per-lane integer to float
  wire logic [VEC_W-1:0] cvt_h2s;  // Four halves widened to singles
  wire logic [DW_W-1:0] cvt_s2h;   // Four singles narrowed to halves

  // Conversion lanes; each lane sees only its own element
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign cvt_f2i[32*i+:32] = f2fix(opa_i[32*i+:32], fb, req_i.uns);
    assign cvt_i2f[32*i+:32] = fix2f(opa_i[32*i+:32], fb, req_i.uns);
    assign cvt_h2s[32*i+:32] = h2s(opa_i[16*i+:16]);
    assign cvt_s2h[16*i+:16] = s2h(opa_i[32*i+:32]);
  end

  // Duplicate source: element of the low doubleword or core register
  wire logic [7:0] dup_sh = 8'({1'b0, req_i.idx, 3'b0} << req_i.es);
  wire logic [DW_W-1:0] dup_elem = opa_i[DW_W-1:0] >> dup_sh;
  wire logic [31:0] dup_src = req_i.from_gpr ? gpr_i : dup_elem[31:0];

  // Extract: count is masked to the legal range of the width
  wire logic [DW_W-1:0] ext_d =
    DW_W'({opb_i[DW_W-1:0], opa_i[DW_W-1:0]} >> {req_i.idx[2:0], 3'b0});
  wire logic [VEC_W-1:0] ext_q = VEC_W'({opb_i, opa_i} >> {req_i.idx, 3'b0});

  // Immediate patterns for each element size
  wire logic [15:0] imm16 = req_i.pos[0] ? {req_i.imm8, 8'h00} : {8'h00, req_i.imm8};
  wire logic [31:0] ones32 = (req_i.ones == 2'h1) ? 32'h000000ff :
                             (req_i.ones == 2'h2) ? 32'h0000ffff : 32'h0;
  wire logic [31:0] imm32 = ({24'h0, req_i.imm8} << {req_i.pos, 3'b0}) | ones32;
  wire logic [31:0] immf =
    {req_i.imm8[7], FIMM_EXP - 8'({5'b0, req_i.imm8[6:4]}), req_i.imm8[3:0], 19'h0};
  wire logic [DW_W-1:0] imm64;
  for (genvar k = 0; k < 8; k++) begin : g_mask
    assign imm64[8*k+:8] = {8{req_i.imm8[k]}};
  end
  wire logic imm_ok = (req_i.es == 2'h1) ? (req_i.ones == 2'h0 && !req_i.pos[1]) :
                      (req_i.es == 2'h2) ? (req_i.ones == 2'h0 || req_i.ones == req_i.pos) :
                      1'b1;
  wire logic [VEC_W-1:0] imm_fill =
    req_i.flt ? {4{immf}} :
    (req_i.es == 2'h0) ? {16{req_i.imm8}} :
    (req_i.es == 2'h1) ? {8{imm16}} :
    (req_i.es == 2'h2) ? {4{imm32}} : {2{imm64}};

  // Reversal: flip the byte index bits between element and span
  wire logic [3:0] rev_flip = 4'((4'h2 << req_i.span) - 4'h1) & ~4'((4'h1 << req_i.es) - 4'h1);
  wire logic rev_ok = req_i.es <= req_i.span;

  // Destinations that are quadword regardless of the width bit
  wire logic quad_dst = req_i.quad || req_i.op == OP_WIDEN || req_i.op == OP_CVT_H2S;
  wire logic go = req_valid_i;
  wire logic wr_next = go && req_i.cond_pass && !ill;

  // Result selection for the issued operation
  always_comb begin
    logic [63:0] v;
    logic [32:0] sr;
    logic sin;
    logic sout;
    v = 64'h0;
    sr = 33'h0;
    sin = (req_i.op == OP_SQNARROWU) || !req_i.uns;
    sout = (req_i.op == OP_SQNARROWU) || req_i.uns;
    res_next = '0;
    sat_any = 1'b0;
    ill = 1'b0;
    case (req_i.op)
      OP_CVT_F2I: res_next = cvt_f2i;
      OP_CVT_I2F: res_next = cvt_i2f;
      OP_CVT_H2S: begin
        res_next = cvt_h2s;
        ill = !HALF_EN;  // Absent option: no write
      end
      OP_CVT_S2H: begin
        res_next = {64'h0, cvt_s2h};
        ill = !HALF_EN;
      end
      OP_DUP: begin
        for (int j = 0; j < 16; j++) begin
          res_next[8*j+:8] = dup_src[8*(j % (1 << req_i.es))+:8];
        end
        ill = req_i.es == 2'h3;
      end
      OP_EXT: res_next = req_i.quad ? ext_q : {64'h0, ext_d};
      OP_MOVI: begin
        res_next = imm_fill;
        ill = !imm_ok || (req_i.flt && req_i.es != 2'h2);
      end
      OP_MVNI: begin
        res_next = ~imm_fill;
        ill = !imm_ok || req_i.flt || req_i.es == 2'h0 || req_i.es == 2'h3;
      end
      OP_WIDEN: begin
        for (int i = 0; i < 8; i++) begin
          case (req_i.es)
            2'h0: res_next[16*i+:16] = {{8{!req_i.uns & opa_i[8*i+7]}}, opa_i[8*i+:8]};
            2'h1: if (i < 4) res_next[32*i+:32] = {{16{!req_i.uns & opa_i[16*i+15]}},
                                                   opa_i[16*i+:16]};
            2'h2: if (i < 2) res_next[64*i+:64] = {{32{!req_i.uns & opa_i[32*i+31]}},
                                                   opa_i[32*i+:32]};
            default: ill = 1'b1;
          endcase
        end
      end
      OP_NARROW, OP_SQNARROW, OP_SQNARROWU: begin
        ill = req_i.es == 2'h3;
        for (int i = 0; i < 8; i++) begin
          case (req_i.es)
            2'h0: v = {{48{sin & opa_i[16*i+15]}}, opa_i[16*i+:16]};
            2'h1: v = (i < 4) ? {{32{sin & opa_i[32*i+31]}}, opa_i[32*i+:32]} : 64'h0;
            default: v = (i < 2) ? opa_i[64*i+:64] : 64'h0;
          endcase
          sr = (req_i.op == OP_NARROW) ? {1'b0, v[31:0]} : sat_nar(v, req_i.es, sin, sout);
          if (i < (8 >> req_i.es)) sat_any = sat_any | sr[32];
          case (req_i.es)
            2'h0: res_next[8*i+:8] = sr[7:0];
            2'h1: if (i < 4) res_next[16*i+:16] = sr[15:0];
            2'h2: if (i < 2) res_next[32*i+:32] = sr[31:0];
            default: res_next[8*i+:8] = 8'h0;
          endcase
        end
      end
      OP_REV: begin
        for (int j = 0; j < 16; j++) begin
          res_next[8*j+:8] = opa_i[8*(j ^ int'(rev_flip))+:8];
        end
        ill = !rev_ok || req_i.span == 2'h3;  // Element not smaller than span
      end
      default: ill = 1'b1;
    endcase
    if (!quad_dst) res_next[VEC_W-1:DW_W] = '0;
  end

  // Result registers; a failed condition holds the old destination
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_reg <= '0;
      valid_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      valid_reg <= go;
      wr_reg <= wr_next;
      if (wr_next) res_reg <= res_next;
    end
  end

  // Sticky flag: a new saturation beats a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sat_reg <= 1'b0;
    end else begin
      sat_reg <= (wr_next && sat_any) || (sat_reg && !sat_clr_i);
    end
  end

  assign res_valid_o = valid_reg;
  assign res_wr_o = wr_reg;
  assign res_o = res_reg;
  assign status_o = 32'(sat_reg) << SAT_BIT;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sat_sticky: assert property (sat_reg && !sat_clr_i |=> status_o[SAT_BIT])
    else $error("saturation flag dropped without clear");
  a_sat_set: assert property (wr_next && sat_any |=> status_o[SAT_BIT])
    else $error("saturation did not set flag");
  a_cond_hold: assert property (go && !req_i.cond_pass |=> !res_wr_o && $stable(res_o))
    else $error("failed condition changed destination");
  a_rev16_swap: assert property (wr_next && req_i.op == OP_REV && req_i.span == 2'h0
    |=> res_o[15:0] == {$past(opa_i[7:0]), $past(opa_i[15:8])})
    else $error("halfword reverse wrong");
  a_dup_core: assert property (wr_next && req_i.op == OP_DUP && req_i.from_gpr
    && req_i.es == 2'h2 |=> res_o[63:32] == $past(gpr_i))
    else $error("duplicate wrong");
  a_ext_zero: assert property (wr_next && req_i.op == OP_EXT && req_i.idx == 4'h0
    |=> res_o[63:0] == $past(opa_i[63:0]))
    else $error("extract by zero wrong");
  a_narrow_low: assert property (wr_next && req_i.op == OP_NARROW && req_i.es == 2'h0
    |=> res_o[15:8] == $past(opa_i[23:16]))
    else $error("plain narrow wrong");
  a_unsat_neg: assert property (wr_next && req_i.op == OP_SQNARROWU && req_i.es == 2'h0
    && opa_i[15] |=> res_o[7:0] == 8'h0 && status_o[SAT_BIT])
    else $error("negative not clamped to zero");
  a_dword_upper: assert property (wr_next && !quad_dst |=> res_o[127:64] == 64'h0)
    else $error("doubleword result spilled");
  a_f2i_small: assert property (wr_next && req_i.op == OP_CVT_F2I && req_i.fbits == 6'h0
    && opa_i[30:23] < 8'h7f |=> res_o[31:0] == 32'h0)
    else $error("fraction below one not truncated");

endmodule : vgdp_datapath

// *** design/vgdp_pkg.sv ***
// Package: opcodes, request carrier and constants of the vector data processing unit
// Functional notes
// - Integer or fixed to float rounds nearest
// - Float to integer or fixed truncates
// - Four 32-bit float/integer conversion pairings
// - Fraction bits 0 to 32; zero means integer
// - Optional half to single conversions, both ways
// - Duplicate scalar or core register everywhere
// - Extract concatenates first low, second high
// - Extract count 0-7 or 0-15 only
// - Immediate move fills every element
// - 16/32-bit immediate byte placements
// - 64-bit immediate is per-byte mask
// - Float immediate is n times 2^-r
// - Inverted move writes immediate complement
// - Inverted move only 16/32-bit forms
// - Widening move sign or zero extends
// - Plain narrowing keeps low halves
// - Saturating narrow clamps to result range
// - Signed to unsigned narrow clamps
// - Halfword reverse swaps bytes
// - Word reverse reorders bytes or halfwords
// - Doubleword reverse reorders bytes, halfwords, words
// - Saturating narrow sets sticky flag bit 27
package vgdp_pkg;

  // Operation codes issued by the pipeline
  typedef enum logic [3:0] {
    OP_CVT_F2I, OP_CVT_I2F, OP_CVT_H2S, OP_CVT_S2H, OP_DUP, OP_EXT,
    OP_MOVI, OP_MVNI, OP_WIDEN, OP_NARROW, OP_SQNARROW, OP_SQNARROWU, OP_REV
  } vgdp_op_type;

  // One issued operation; operands travel beside it
  typedef struct packed {
    vgdp_op_type op;  // Operation
    logic quad;       // 1: quadword, 0: doubleword
    logic [1:0] es;   // Element size 8 << es bits
    logic uns;        // Unsigned element type
    logic flt;        // Float immediate
    logic [1:0] span; // Reversal span 16 << span bits
    logic [5:0] fbits; // Fraction bits
    logic from_gpr;   // Duplicate source is core register
    logic [3:0] idx;  // Element index or extract byte count
    logic [7:0] imm8; // Immediate byte
    logic [1:0] pos;  // Immediate byte position
    logic [1:0] ones; // Ones bytes below immediate byte
    logic cond_pass;  // Condition passed
  } vgdp_req_type;

  localparam int VEC_W = 128;            // Quadword width
  localparam int DW_W = 64;              // Doubleword width
  localparam logic [5:0] FBITS_MAX = 6'h20;  // Largest fraction count
  localparam int SAT_BIT = 27;           // Sticky flag position in status word
  localparam logic [9:0] F32_BIAS = 10'h07f;  // Single exponent bias
  localparam logic [7:0] F32_EXP_TOP = 8'h9e; // Bias plus 31 for normalising
  localparam logic [7:0] F16_REBIAS = 8'h70;  // Single minus half bias
  localparam logic [9:0] F2I_MAX_EXP = 10'h028; // Beyond this, saturate
  localparam logic [7:0] FIMM_EXP = 8'h83;    // Bias plus 4 for n in 16..31

endpackage : vgdp_pkg

// *** verification/vgdp_pipe_model.sv ***
// Pipeline model: presents vector requests and operands to the datapath
module vgdp_pipe_model import vgdp_pkg::*; (
  input wire logic core_clk_i,
  output logic req_valid_o,
  output vgdp_req_type req_o,
  output logic [127:0] opa_o,
  output logic [127:0] opb_o,
  output logic [31:0] gpr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus at time zero
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
    opa_o = '0;
    opb_o = '0;
    gpr_o = '0;
  end

  // Called just after a rising edge; everything changes together by NBA
  task automatic put(logic v, vgdp_req_type r, logic [127:0] a, logic [127:0] b,
                     logic [31:0] g);
    logic [63:0] z;
    z = {$urandom, $urandom};
    if (r.op == OP_EXT && !r.quad) begin
      r.idx[3] = 1'b0;
    end
    if (r.op == OP_REV && r.es > r.span) begin
      r.es = r.span;
    end
    req_valid_o <= v;
    // Idle cycles carry junk, so a stale operand can never look right
    req_o <= v ? r : z[$bits(vgdp_req_type)-1:0];
    opa_o <= v ? a : {z, ~z};
    opb_o <= v ? b : {~z, z};
    gpr_o <= v ? g : z[31:0];
  endtask : put
endmodule : vgdp_pipe_model

// *** verification/tb_top.sv ***
// Testbench: drives the datapath through the pipeline model and checks each result
module tb_top import vgdp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

  typedef struct {logic wr; logic [127:0] res; logic sat; int due;} vgdp_note_type;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sat_clr = 1'b0;
  logic req_valid, res_valid, res_wr;
  vgdp_req_type req;
  logic [127:0] opa, opb, res;
  logic [31:0] gpr, status;
  vgdp_note_type notes[$];  // Expected results, oldest first
  vgdp_note_type nt;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [127:0] last_res = '0;  // Destination holds this when nothing is written
  logic flag = 1'b0;            // Expected sticky flag

  vgdp_pipe_model i_pipe (.core_clk_i(core_clk), .req_valid_o(req_valid), .req_o(req),
    .opa_o(opa), .opb_o(opb), .gpr_o(gpr));
  vgdp_datapath #(.HALF_EN(1'b1)) i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .req_valid_i(req_valid), .req_i(req), .opa_i(opa), .opb_i(opb), .gpr_i(gpr),
    .sat_clr_i(sat_clr), .res_valid_o(res_valid), .res_wr_o(res_wr), .res_o(res),
    .status_o(status));

  // 200 MHz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [127:0] msk(int w);
    return (w >= 128) ? '1 : ((128'h1 << w) - 1);
  endfunction : msk

  function automatic logic [127:0] fld(logic [127:0] v, int i, int w);
    return (v >> (i * w)) & msk(w);
  endfunction : fld

  // Reference result of one operation; s reports any clamped element
  function automatic logic [127:0] ref_res(vgdp_req_type r, logic [127:0] a, logic [127:0] b,
                                           logic [31:0] g, output logic s);
    logic [127:0] x, v, y, hi;
    int w, n, e;
    x = '0;
    v = '0;
    s = 1'b0;
    w = 8 << r.es;
    n = 2 << r.span;
    e = 1 << r.es;
    case (r.op)
      OP_REV: for (int p = 0; p < 16; p++) begin
        x |= fld(a, (p / n) * n + n - e - (p % n) / e * e + p % e, 8) << (8 * p);
      end
      OP_EXT: x = r.quad ? 128'({b, a} >> (8 * r.idx)) :
                           128'({b[63:0], a[63:0]} >> (8 * r.idx[2:0])) & msk(64);
      OP_WIDEN, OP_NARROW, OP_SQNARROW, OP_SQNARROWU: for (int i = 0; i < 64 / w; i++) begin
        if (r.op == OP_WIDEN) begin
          // Sign bit copied upward only for signed elements
          v = fld(a, i, w);
          if (!r.uns && v[w-1]) v |= msk(2 * w) & ~msk(w);
          x |= v << (i * 2 * w);
        end else begin
          v = fld(a, i, 2 * w);
          y = v & msk(w);
          hi = v >> (w - 1);
          if (r.op == OP_SQNARROWU && v[2*w-1]) begin y = '0; s = 1'b1; end
          else if (r.op == OP_SQNARROWU && (v >> w) != 0) begin y = msk(w); s = 1'b1; end
          else if (r.op == OP_SQNARROW && r.uns && (v >> w) != 0) begin y = msk(w); s = 1'b1; end
          else if (r.op == OP_SQNARROW && !r.uns && hi != 0 && hi != msk(w + 1)) begin
            y = v[2*w-1] ? (128'h1 << (w - 1)) : msk(w - 1);
            s = 1'b1;
          end
          x |= y << (i * w);
        end
      end
      default: begin
        // Duplicate and immediate moves build one element, then fill
        if (r.op == OP_DUP) v = r.from_gpr ? 128'(g) : fld(a, r.idx, w);
        else if (r.flt) v = {r.imm8[7], 8'(8'd131 - r.imm8[6:4]), r.imm8[3:0], 19'h0};
        else if (r.es == 2'h0) v = r.imm8;
        else if (r.es == 2'h1) v = r.imm8 << (8 * r.pos[0]);
        else if (r.es == 2'h2) v = (r.imm8 << (8 * r.pos)) | msk(8 * r.ones);
        else for (int k = 0; k < 8; k++) v |= {8{r.imm8[k]}} << (8 * k);
        if (r.op == OP_MVNI) v = ~v;
        for (int i = 0; i < 128 / w; i++) x |= (v & msk(w)) << (i * w);
      end
    endcase
    if (!r.quad && r.op inside {OP_REV, OP_DUP, OP_MOVI, OP_MVNI}) x &= msk(64);
    return x;
  endfunction : ref_res

  function automatic vgdp_req_type rq(vgdp_op_type op, logic [1:0] es, logic q, logic u);
    rq = '0;
    rq.op = op;
    rq.es = es;
    rq.quad = q;
    rq.uns = u;
    rq.cond_pass = 1'b1;
  endfunction : rq

  function automatic logic [127:0] rnd();
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction : rnd

  // Note the outcome, then present the request; m: 0 given result, 1 refused, 2 clear flag
  task automatic go(vgdp_req_type r, logic [127:0] a, logic [127:0] b, logic [31:0] g,
                    logic [127:0] e, logic [2:0] m);
    vgdp_note_type t;
    logic s;
    logic [127:0] x;
    s = 1'b0;
    x = m[0] ? e : ref_res(r, a, b, g, s);
    t.wr = r.cond_pass & !m[1];
    if (!t.wr) begin x = last_res; s = 1'b0; end
    flag = s | (flag & !m[2]);  // Set wins over a clear at the same edge
    last_res = x;
    @(posedge core_clk);
    t.res = x;
    t.sat = flag;
    t.due = cyc + 2;
    notes.push_back(t);
    sat_clr <= m[2];
    i_pipe.put(1'b1, r, a, b, g);
  endtask : go

  task automatic stop_test();
    $display("Comparisons %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Each result pulse takes the oldest note and checks it
  always @(posedge core_clk) begin
    #1;
    cyc++;
    if (res_valid === 1'b1) begin
      if (notes.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        nt = notes.pop_front();
        `CHK(cyc, nt.due)
        `CHK(res_wr, nt.wr)
        `CHK(res, nt.res)
        `CHK(status, 32'(nt.sat) << 27)
      end
    end
  end

  // Main sequence
  initial begin
    vgdp_req_type r;
    logic [127:0] a;
    void'($urandom(32'h76e47c6b));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int q = 0; q < 2; q++) begin
      for (int sp = 0; sp < 3; sp++) for (int e = 0; e <= sp; e++) begin
        r = rq(OP_REV, 2'(e), q[0], 1'b0);
        r.span = 2'(sp);
        go(r, rnd(), '0, '0, '0, 3'h0);
      end
      for (int k = 0; k < 3; k++) begin
        r = rq(OP_EXT, 2'h0, q[0], 1'b0);
        r.idx = (k == 0) ? 4'h0 : (k == 1) ? {q[0], 3'h7} : 4'($urandom_range(q ? 15 : 7));
        go(r, rnd(), rnd(), '0, '0, 3'h0);
      end
      for (int e = 0; e < 3; e++) begin
        r = rq(OP_DUP, 2'(e), q[0], 1'b0);
        r.from_gpr = 1'b1;
        go(r, rnd(), '0, $urandom, '0, 3'h0);
        r.from_gpr = 1'b0;
        r.idx = 4'($urandom_range((8 >> e) - 1));
        go(r, rnd(), '0, $urandom, '0, 3'h0);
      end
      // Immediate moves: every size and byte place; inverted form 16/32 only
      for (int o = 0; o < 2; o++) for (int e = 0; e < 4; e++) for (int p = 0; p < 4; p++) begin
        r = rq(o ? OP_MVNI : OP_MOVI, 2'(e), q[0], 1'b0);
        r.imm8 = 8'($urandom);
        r.pos = (e == 2) ? 2'(p) : (e == 1) ? 2'(p & 1) : 2'h0;
        r.ones = (e == 2 && p > 0 && p < 3) ? r.pos : 2'h0;
        go(r, '0, '0, '0, '0, (o && (e == 0 || e == 3)) ? 3'h2 : 3'h0);
        r.flt = 1'b1;
        r.es = 2'h2;
        go(r, '0, '0, '0, '0, o ? 3'h2 : 3'h0);
      end
    end
    for (int e = 0; e < 3; e++) begin
      for (int u = 0; u < 2; u++) go(rq(OP_WIDEN, 2'(e), 1'b1, u[0]), rnd(), '0, '0, '0, 3'h0);
      go(rq(OP_NARROW, 2'(e), 1'b1, 1'b0), rnd(), '0, '0, '0, 3'h0);
      for (int u = 0; u < 3; u++) begin
        r = rq(u == 2 ? OP_SQNARROWU : OP_SQNARROW, 2'(e), 1'b1, u[0]);
        go(r, rnd(), '0, '0, '0, 3'h0);
        go(r, '0, '0, '0, '0, 3'h4);
        go(r, rnd(), '0, '0, '0, 3'h4);
        r.cond_pass = 1'b0;
        go(r, rnd(), '0, '0, '0, 3'h4);
      end
    end
    a = {32'h0, 32'h01000001, 32'hffffffff, 32'h1};
    go(rq(OP_CVT_I2F, 2'h2, 1'b1, 1'b0), a, '0, '0,
       {32'h0, 32'h4b800000, 32'hbf800000, 32'h3f800000}, 3'h1);
    go(rq(OP_CVT_I2F, 2'h2, 1'b1, 1'b1), a, '0, '0,
       {32'h0, 32'h4b800000, 32'h4f800000, 32'h3f800000}, 3'h1);
    a = {32'h40490fdb, 32'hc0200000, 32'h3fc00000, 32'h0};
    go(rq(OP_CVT_F2I, 2'h2, 1'b1, 1'b0), a, '0, '0, {32'h3, 32'hfffffffe, 32'h1, 32'h0}, 3'h1);
    go(rq(OP_CVT_F2I, 2'h2, 1'b1, 1'b1), a, '0, '0, {32'h3, 32'h0, 32'h1, 32'h0}, 3'h1);
    r = rq(OP_CVT_F2I, 2'h2, 1'b1, 1'b0);
    r.fbits = 6'h04;
    go(r, a, '0, '0, {32'h32, 32'hffffffd8, 32'h18, 32'h0}, 3'h1);
    r.fbits = 6'h20;
    r.uns = 1'b1;
    go(r, {4{32'h3f000000}}, '0, '0, {4{32'h80000000}}, 3'h1);
    r = rq(OP_CVT_I2F, 2'h2, 1'b1, 1'b0);
    r.fbits = 6'h01;
    go(r, {4{32'h3}}, '0, '0, {4{32'h3fc00000}}, 3'h1);
    a = {32'h477fe000, 32'h3eaaa000, 32'hc0000000, 32'h3f800000};
    go(rq(OP_CVT_H2S, 2'h1, 1'b1, 1'b0), {64'h0, 64'h7bff3555c0003c00}, '0, '0, a, 3'h1);
    go(rq(OP_CVT_S2H, 2'h2, 1'b0, 1'b0), a, '0, '0, {64'h0, 64'h7bff3555c0003c00}, 3'h1);
    @(posedge core_clk);
    sat_clr <= 1'b0;
    i_pipe.put(1'b0, '0, '0, '0, '0);
    // Bounded drain of outstanding results
    for (int k = 0; k < 20 && notes.size() > 0; k++) @(posedge core_clk);
    if (notes.size() > 0) errors++;
    stop_test();
  end
endmodule : tb_top
